// [rtl/sdlnr_top.sv]
// luma noise coring / sharpening and active-video edge limiter, AHB-Lite registers
// assumes a 4:2:2 stream synchronous to hclk, one sample per valid cycle,
// luma and chroma interleaved so one pixel spans two samples
//
// Notes on behaviour
// - only luma is processed; chroma samples pass through unchanged
// - three-bit select picks the high-pass filter feeding the noise stage
// - absolute filter output is compared with threshold to class noise or signal
// - threshold is six-bit unsigned, 0 to 63
// - mode bit: 0 coring, 1 sharpness
// - coring: below threshold, gain times filter output is subtracted from luma
// - sharpness: above threshold, gain times filter output is added to luma
// - low nibble of gains register is the border gain
// - high nibble of gains register is the block-interior gain
// - coring gain runs 0 to 1 in eighths
// - sharpness gain runs 0 to one half in sixteenths
// - border-width bit: four-pixel border when set, two when clear
// - block-size bit: 16x16 blocks when set, 8x8 when clear
// - four-bit offset shifts data against border positions by 0 to 15 pixels
// - edge enable scales first three active luma pixels by 1/8, 1/2, 7/8
// - edge enable scales last three active luma pixels by 7/8, 1/2, 1/8
// - other active pixels untouched by the limiter; chroma never scaled
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sdlnr_top #(
    parameter int LINE_PIX = 720,
    parameter int CNT_W = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic in_valid,
    input wire logic in_luma,
    input wire logic in_active,
    input wire logic in_sol,
    input wire logic in_sof,
    input wire logic [7:0] in_data,
    output logic out_valid,
    output logic out_luma,
    output logic out_active,
    output logic [7:0] out_data
);

    // ==========================================================
    // elaboration checks
    generate
        if (LINE_PIX < 6 || LINE_PIX >= (1 << CNT_W) || CNT_W > 16)
        begin : g_bad_params
            $error("sdlnr_top needs 6 <= LINE_PIX < 2**CNT_W and CNT_W <= 16");
        end
    endgenerate

    localparam logic [CNT_W-1:0] PIX_LAST = CNT_W'(LINE_PIX - 1);
    localparam logic [CNT_W-1:0] PIX_LAST2 = CNT_W'(LINE_PIX - 2);
    localparam logic [CNT_W-1:0] PIX_LAST3 = CNT_W'(LINE_PIX - 3);

    // ==========================================================
    // bus slave: zero wait states, always OKAY
    logic [7:0] gains_ff;
    logic [7:0] thrblk_ff;
    logic [7:0] modeoff_ff;
    logic edge_en_ff;
    logic [7:0] nxt_gains;
    logic [7:0] nxt_thrblk;
    logic [7:0] nxt_modeoff;
    logic nxt_edge_en;
    logic wr_pend_ff;
    logic [9:0] wr_idx_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    logic [CNT_W-1:0] pix_ff;
    logic [CNT_W-1:0] line_ff;

    wire addr_take = hsel & hready & htrans[sdlnr_pkg::HTRANS_ACTIVE_BIT];
    wire [9:0] addr_idx = haddr[11:2];
    wire wr_gains = wr_pend_ff & (wr_idx_ff == sdlnr_pkg::IDX_GAINS);
    wire wr_thrblk = wr_pend_ff & (wr_idx_ff == sdlnr_pkg::IDX_THR_BLOCK);
    wire wr_modeoff = wr_pend_ff & (wr_idx_ff == sdlnr_pkg::IDX_MODE_OFFSET);
    wire wr_edge = wr_pend_ff & (wr_idx_ff == sdlnr_pkg::IDX_EDGE_CTRL);
    wire [31:0] pos_word = (32'(line_ff) << sdlnr_pkg::POS_LINE_LSB) | 32'(pix_ff);

    // next register values double as read forwarding, so a read right
    // behind a write to the same register sees the new value
    assign nxt_gains = wr_gains ? hwdata[7:0] : gains_ff;
    assign nxt_thrblk = wr_thrblk ? hwdata[7:0] : thrblk_ff;
    assign nxt_modeoff = wr_modeoff ? hwdata[7:0] : modeoff_ff;
    assign nxt_edge_en = wr_edge ? hwdata[sdlnr_pkg::EDGE_EN_BIT] : edge_en_ff;
    assign nxt_hrdata =
        (addr_idx == sdlnr_pkg::IDX_GAINS) ? {24'h000000, nxt_gains} :
        (addr_idx == sdlnr_pkg::IDX_THR_BLOCK) ? {24'h000000, nxt_thrblk} :
        (addr_idx == sdlnr_pkg::IDX_MODE_OFFSET) ? {24'h000000, nxt_modeoff} :
        (addr_idx == sdlnr_pkg::IDX_EDGE_CTRL) ?
            (32'(nxt_edge_en) << sdlnr_pkg::EDGE_EN_BIT) :
        (addr_idx == sdlnr_pkg::IDX_POSITION) ? pos_word : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp = sdlnr_pkg::HRESP_OKAY;
    assign hrdata = hrdata_ff;

    // address phase capture; unmapped writes fall through every decode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 10'h000;
            hrdata_ff <= 32'h00000000;
        end
        else
        begin
            wr_pend_ff <= addr_take & hwrite;
            if (addr_take)
                wr_idx_ff <= addr_idx;
            if (addr_take & ~hwrite)
                hrdata_ff <= nxt_hrdata;
        end
    end

    // configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gains_ff <= sdlnr_pkg::RST_GAINS;
            thrblk_ff <= sdlnr_pkg::RST_THR_BLOCK;
            modeoff_ff <= sdlnr_pkg::RST_MODE_OFFSET;
            edge_en_ff <= sdlnr_pkg::RST_EDGE_EN;
        end
        else
        begin
            gains_ff <= nxt_gains;
            thrblk_ff <= nxt_thrblk;
            modeoff_ff <= nxt_modeoff;
            edge_en_ff <= nxt_edge_en;
        end
    end

    // ==========================================================
    // field decode
    wire [3:0] gain_border = gains_ff[sdlnr_pkg::GAIN_BORDER_LSB +: 4];
    wire [3:0] gain_data = gains_ff[sdlnr_pkg::GAIN_DATA_LSB +: 4];
    wire [5:0] thr = thrblk_ff[sdlnr_pkg::THR_LSB +: 6];
    wire border_wide = thrblk_ff[sdlnr_pkg::BORDER_WIDE_BIT];
    wire block16 = thrblk_ff[sdlnr_pkg::BLOCK16_BIT];
    wire [2:0] filt_sel = modeoff_ff[sdlnr_pkg::SEL_LSB +: 3];
    wire [3:0] blk_offset = modeoff_ff[sdlnr_pkg::OFFSET_LSB +: 4];
    sdlnr_pkg::sdlnr_mode_t mode;
    assign mode = sdlnr_pkg::sdlnr_mode_t'(modeoff_ff[sdlnr_pkg::MODE_BIT]);

    // ==========================================================
    // position counters, counted in luma samples (one per pixel)
    wire luma_take = in_valid & in_luma & in_active;
    logic [CNT_W-1:0] pix_idx;
    logic [CNT_W-1:0] line_cur;

    assign pix_idx = in_sol ? '0 : pix_ff;
    assign line_cur = in_sol ? (in_sof ? '0 : line_ff + 1'b1) : line_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pix_ff <= '0;
            line_ff <= '0;
        end
        else if (luma_take)
        begin
            pix_ff <= pix_idx + 1'b1;
            line_ff <= line_cur;
        end
    end

    // ==========================================================
    // block border map; offset moves the data under fixed border slots
    wire [3:0] blk_mask = block16 ? sdlnr_pkg::BLK_MASK_16 : sdlnr_pkg::BLK_MASK_8;
    wire [3:0] half = border_wide ? sdlnr_pkg::HALF_WIDE : sdlnr_pkg::HALF_NARROW;
    wire [3:0] hpos = (pix_idx[3:0] + blk_offset) & blk_mask;
    wire [3:0] vpos = line_cur[3:0] & blk_mask;
    wire h_border = (hpos < half) | (hpos > (blk_mask - half));
    wire v_border = (vpos < half) | (vpos > (blk_mask - half));
    wire in_border = h_border | v_border;

    // ==========================================================
    // filter, threshold and gain
    logic signed [10:0] hp;

    sdlnr_hpf #(
        .TAPS(2)
    ) u_hpf (
        .hclk(hclk),
        .hresetn(hresetn),
        .take(luma_take),
        .restart(in_sol),
        .y_in(in_data),
        .sel(filt_sel),
        .hp(hp)
    );

    wire [10:0] abs_hp = hp[10] ? 11'(-hp) : 11'(hp);
    wire below_thr = abs_hp < {5'b00000, thr};
    wire above_thr = abs_hp > {5'b00000, thr};
    wire [3:0] gain_code = in_border ? gain_border : gain_data;
    // both modes top out at code 8: 8/8 for coring, 8/16 for sharpness
    wire [3:0] gain_eff = (gain_code > sdlnr_pkg::GAIN_MAX_CODE) ?
                          sdlnr_pkg::GAIN_MAX_CODE : gain_code;
    wire signed [15:0] prod = 16'(hp) * $signed({12'h000, gain_eff});
    wire signed [15:0] scaled = (mode == sdlnr_pkg::SDLNR_MODE_SHARP) ?
                                (prod >>> sdlnr_pkg::SHARP_SHIFT) :
                                (prod >>> sdlnr_pkg::CORE_SHIFT);
    wire do_core = (mode == sdlnr_pkg::SDLNR_MODE_CORING) & below_thr;
    wire do_sharp = (mode == sdlnr_pkg::SDLNR_MODE_SHARP) & above_thr;
    wire signed [16:0] y_ext = $signed({9'h000, in_data});
    wire signed [16:0] sum = do_core ? (y_ext - 17'(scaled)) :
                             (y_ext + 17'(scaled));

    // saturate rather than wrap, a wrapped dark pixel would flash white
    logic [7:0] sat_y;
    assign sat_y = (sum < $signed({9'h000, sdlnr_pkg::LUMA_MIN})) ? sdlnr_pkg::LUMA_MIN :
                   (sum > $signed({9'h000, sdlnr_pkg::LUMA_MAX})) ? sdlnr_pkg::LUMA_MAX :
                   sum[7:0];
    wire [7:0] nr_y = (do_core | do_sharp) ? sat_y : in_data;

    // ==========================================================
    // active-video edge limiter, scale k/8 on the three end pixels
    logic [3:0] edge_k;
    assign edge_k = !edge_en_ff ? sdlnr_pkg::EDGE_K_UNITY :
        (pix_idx == '0) ? sdlnr_pkg::EDGE_K_OUTER :
        (pix_idx == CNT_W'(1)) ? sdlnr_pkg::EDGE_K_MID :
        (pix_idx == CNT_W'(2)) ? sdlnr_pkg::EDGE_K_INNER :
        (pix_idx == PIX_LAST3) ? sdlnr_pkg::EDGE_K_INNER :
        (pix_idx == PIX_LAST2) ? sdlnr_pkg::EDGE_K_MID :
        (pix_idx == PIX_LAST) ? sdlnr_pkg::EDGE_K_OUTER :
        sdlnr_pkg::EDGE_K_UNITY;
    wire [11:0] edge_prod = {4'h0, nr_y} * {8'h00, edge_k};
    wire [11:0] edge_shift = edge_prod >> sdlnr_pkg::EDGE_SHIFT;
    wire [7:0] proc_y = edge_shift[7:0];
    // chroma and blanking bypass every stage
    wire [7:0] nxt_out_data = luma_take ? proc_y : in_data;

    // ==========================================================
    // output register, one cycle latency
    logic out_valid_ff;
    logic out_luma_ff;
    logic out_active_ff;
    logic [7:0] out_data_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_valid_ff <= 1'b0;
            out_luma_ff <= 1'b0;
            out_active_ff <= 1'b0;
            out_data_ff <= 8'h00;
        end
        else
        begin
            out_valid_ff <= in_valid;
            out_luma_ff <= in_luma;
            out_active_ff <= in_active;
            out_data_ff <= nxt_out_data;
        end
    end

    assign out_valid = out_valid_ff;
    assign out_luma = out_luma_ff;
    assign out_active = out_active_ff;
    assign out_data = out_data_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_chroma_pass:
        assert property (in_valid && !in_luma |=> out_data == $past(in_data))
        else $error("chroma sample altered");
    a_coring_gate:
        assert property (luma_take && mode == sdlnr_pkg::SDLNR_MODE_CORING && !below_thr
                         |-> nr_y == in_data)
        else $error("coring touched a sample at or above threshold");
    a_sharp_gate:
        assert property (luma_take && mode == sdlnr_pkg::SDLNR_MODE_SHARP && !above_thr
                         |-> nr_y == in_data)
        else $error("sharpening touched a sample at or below threshold");
    a_sat_range:
        assert property (luma_take && (do_core || do_sharp)
                         |-> nr_y >= sdlnr_pkg::LUMA_MIN && nr_y <= sdlnr_pkg::LUMA_MAX)
        else $error("processed luma outside legal range");
    a_gain_clamp:
        assert property (gain_code >= sdlnr_pkg::GAIN_MAX_CODE
                         |-> gain_eff == sdlnr_pkg::GAIN_MAX_CODE)
        else $error("gain code not clamped");
    a_edge_first:
        assert property (luma_take && in_sol && edge_en_ff
                         |=> out_data == 8'($past(nr_y) >> 3))
        else $error("first active pixel not scaled by one eighth");
    a_edge_last:
        assert property (luma_take && !in_sol && pix_ff == PIX_LAST && edge_en_ff
                         |=> out_data == 8'($past(nr_y) >> 3))
        else $error("last active pixel not scaled by one eighth");
    a_edge_mid:
        assert property (luma_take && !in_sol && pix_ff == CNT_W'(5)
                         |=> out_data == $past(nr_y))
        else $error("interior pixel altered by edge limiter");
    a_pix_restart:
        assert property (luma_take && in_sol |=> pix_ff == CNT_W'(1))
        else $error("pixel counter did not restart");
    a_border_narrow:
        assert property (!border_wide && hpos == 4'h1 && !v_border |-> !in_border)
        else $error("narrow border wider than two pixels");
    a_border_wide:
        assert property (border_wide && hpos == 4'h1 |-> in_border)
        else $error("wide border missing second pixel");
    a_reg_write:
        assert property (wr_modeoff |=> modeoff_ff == $past(hwdata[7:0]))
        else $error("mode register write lost");

endmodule
`default_nettype wire

// [rtl/sdlnr_pkg.sv]
// package for the luma noise coring and edge limiter stage
// assumes one 100 MHz bus clock that also carries the 4:2:2 pixel stream
package sdlnr_pkg;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_EDGE_CTRL = 10'h082;
    localparam logic [9:0] IDX_GAINS = 10'h0a3;
    localparam logic [9:0] IDX_THR_BLOCK = 10'h0a4;
    localparam logic [9:0] IDX_MODE_OFFSET = 10'h0a5;
    localparam logic [9:0] IDX_POSITION = 10'h0c0;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_GAINS = 8'h00;
    localparam logic [7:0] RST_THR_BLOCK = 8'h00;
    localparam logic [7:0] RST_MODE_OFFSET = 8'h00;
    localparam logic RST_EDGE_EN = 1'b0;

    // ==========================================================
    // field positions
    localparam int unsigned GAIN_BORDER_LSB = 0;
    localparam int unsigned GAIN_DATA_LSB = 4;
    localparam int unsigned THR_LSB = 0;
    localparam int unsigned BORDER_WIDE_BIT = 6;
    localparam int unsigned BLOCK16_BIT = 7;
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned MODE_BIT = 3;
    localparam int unsigned OFFSET_LSB = 4;
    localparam int unsigned EDGE_EN_BIT = 7;
    localparam int unsigned POS_LINE_LSB = 16;

    // ==========================================================
    // arithmetic constants
    localparam logic [3:0] GAIN_MAX_CODE = 4'h8;
    localparam int unsigned CORE_SHIFT = 3;
    localparam int unsigned SHARP_SHIFT = 4;
    localparam int unsigned EDGE_SHIFT = 3;
    localparam logic [7:0] LUMA_MIN = 8'h10;
    localparam logic [7:0] LUMA_MAX = 8'heb;
    localparam logic [3:0] EDGE_K_OUTER = 4'h1;
    localparam logic [3:0] EDGE_K_MID = 4'h4;
    localparam logic [3:0] EDGE_K_INNER = 4'h7;
    localparam logic [3:0] EDGE_K_UNITY = 4'h8;
    localparam logic [3:0] BLK_MASK_8 = 4'h7;
    localparam logic [3:0] BLK_MASK_16 = 4'hf;
    localparam logic [3:0] HALF_NARROW = 4'h1;
    localparam logic [3:0] HALF_WIDE = 4'h2;

    // ==========================================================
    // bus constants
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic {
        SDLNR_MODE_CORING = 1'b0,
        SDLNR_MODE_SHARP = 1'b1
    } sdlnr_mode_t;

endpackage

// [rtl/sdlnr_hpf.sv]
// selectable high-pass filter on the luma samples of the stream
// assumes take marks a luma sample and restart marks the first one of a line
`timescale 1ns/1ps
`default_nettype none
module sdlnr_hpf #(
    parameter int TAPS = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic take,
    input wire logic restart,
    input wire logic [7:0] y_in,
    input wire logic [2:0] sel,
    output logic signed [10:0] hp
);

    // ==========================================================
    // elaboration check
    generate
        if (TAPS != 2)
        begin : g_bad_taps
            $error("sdlnr_hpf kernels need exactly two history taps");
        end
    endgenerate

    // ==========================================================
    // history taps, refilled with the current sample at line start
    // so that no energy leaks in from the previous line
    logic [7:0] tap_ff [TAPS];
    logic [7:0] tap_src [TAPS];
    logic [7:0] tap_eff [TAPS];

    genvar i;
    generate
        for (i = 0; i < TAPS; i++)
        begin : g_tap
            if (i == 0)
            begin : g_first
                assign tap_src[i] = y_in;
            end
            else
            begin : g_rest
                assign tap_src[i] = restart ? y_in : tap_ff[i-1];
            end
            assign tap_eff[i] = restart ? y_in : tap_ff[i];
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    tap_ff[i] <= 8'h00;
                else if (take)
                    tap_ff[i] <= tap_src[i];
            end
        end
    endgenerate

    // ==========================================================
    // kernels: low bits pick the shape, top bit narrows the gain
    logic signed [10:0] c0;
    logic signed [10:0] c1;
    logic signed [10:0] c2;
    logic signed [10:0] d_one;
    logic signed [10:0] d_two;
    logic signed [10:0] d_span;
    logic signed [10:0] raw;

    assign c0 = $signed({3'b000, y_in});
    assign c1 = $signed({3'b000, tap_eff[0]});
    assign c2 = $signed({3'b000, tap_eff[1]});
    assign d_one = c0 - c1;
    assign d_two = (c0 <<< 1) - c1 - c2;
    assign d_span = c0 - c2;
    assign raw = (sel[1:0] == 2'b00) ? d_one :
                 (sel[1:0] == 2'b01) ? (d_two >>> 1) :
                 (sel[1:0] == 2'b10) ? (d_span >>> 1) : (d_two >>> 2);
    assign hp = sel[2] ? (raw >>> 1) : raw;

endmodule
`default_nettype wire

// [test/sdlnr_src_model.sv]
// upstream video source: one line of interleaved luma/chroma samples per go pulse
// assumes go is a one-cycle pulse given while busy is low
`timescale 1ns/1ps
`default_nettype none
module sdlnr_src_model #(
    parameter int LINE_PIX = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic sof,
    input wire logic gap,
    input wire logic [7:0] y_line [LINE_PIX],
    output logic busy,
    output logic in_valid,
    output logic in_luma,
    output logic in_active,
    output logic in_sol,
    output logic in_sof,
    output logic [7:0] in_data
);
    // ==========================================================
    // sample sequencer
    logic [15:0] n_ff;
    logic hole_ff;

    // idle slots show the inverse of the last value, never a stale copy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {busy, in_valid, in_luma, in_active, in_sol, in_sof, hole_ff} <= '0;
            in_data <= 8'h00;
            n_ff <= 16'h0000;
        end
        else if (!busy || hole_ff)
        begin
            busy <= busy | go;
            n_ff <= busy ? n_ff : 16'h0000;
            hole_ff <= 1'b0;
            {in_valid, in_active, in_sol, in_sof} <= '0;
            in_data <= ~in_data;
        end
        else
        begin
            {in_valid, in_active} <= 2'b11;
            in_luma <= !n_ff[0];
            in_sol <= (n_ff == 16'h0000);
            in_sof <= (n_ff == 16'h0000) && sof;
            in_data <= n_ff[0] ? 8'h80 + n_ff[7:0] : y_line[n_ff[15:1]];
            hole_ff <= gap; // slow source: an empty slot after every sample
            n_ff <= n_ff + 16'h0001;
            busy <= (n_ff != 16'(2 * LINE_PIX - 1));
        end
    end
endmodule
`default_nettype wire

// [test/sdlnr_tb_top.sv]
// self-checking bench: AHB-Lite register access and random lines through the luma stage
// assumes the design answers in zero wait states but waits on hready anyway
`timescale 1ns/1ps
`default_nettype none
module sdlnr_tb_top;
    localparam int LP = 16;
    logic hclk = 1'b0;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, sof = 1'b0, gap = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, hrdata, q, r;
    logic hreadyout, hresp, busy, in_valid, in_luma, in_active, in_sol, in_sof;
    logic out_valid, out_luma, out_active, e_v = 1'b0, e_l, e_a, c_en = 1'b0;
    logic [7:0] in_data, out_data, y_line [LP], h1, h2, e, e_d, c_g = 0, c_tb = 0, c_mo = 0;
    logic [31:0] lf = 32'hd6cf;
    wire hready;
    int err_total = 0, cmp_count = 0, cyc = 0, pidx = 0, lidx = 0;

    assign hready = hreadyout; // single slave drives the bus ready
    always #5 hclk = ~hclk;

    sdlnr_top #(.LINE_PIX(LP), .CNT_W(10)) i_sdlnr_top (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .in_valid(in_valid), .in_luma(in_luma), .in_active(in_active),
        .in_sol(in_sol), .in_sof(in_sof), .in_data(in_data), .out_valid(out_valid),
        .out_luma(out_luma), .out_active(out_active), .out_data(out_data));
    sdlnr_src_model #(.LINE_PIX(LP)) i_sdlnr_src_model (.hclk(hclk), .hresetn(hresetn),
        .go(go), .sof(sof), .gap(gap), .y_line(y_line), .busy(busy), .in_valid(in_valid),
        .in_luma(in_luma), .in_active(in_active), .in_sol(in_sol), .in_sof(in_sof),
        .in_data(in_data));

    // ==========================================================
    // reference arithmetic
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // expected luma from the current and two previous samples of the line
    function automatic logic [7:0] exp_luma(input logic [7:0] y, y1, y2, input int i, ln);
        int s, a, g, v, m, hf, hp, vp;
        logic brd, hit;
        case (c_mo[1:0])
            2'd0: s = int'(y) - int'(y1);
            2'd1: s = (2 * int'(y) - int'(y1) - int'(y2)) >>> 1;
            2'd2: s = (int'(y) - int'(y2)) >>> 1;
            default: s = (2 * int'(y) - int'(y1) - int'(y2)) >>> 2;
        endcase
        if (c_mo[2])
            s = s >>> 1;
        m = c_tb[7] ? 15 : 7;
        hf = c_tb[6] ? 2 : 1;
        hp = ((i % 16) + int'(c_mo[7:4])) & m;
        vp = (ln % 16) & m;
        brd = hp < hf || hp > m - hf || vp < hf || vp > m - hf;
        g = brd ? int'(c_g[3:0]) : int'(c_g[7:4]);
        g = g > 8 ? 8 : g; // codes above the maximum clamp
        a = s < 0 ? -s : s;
        v = int'(y);
        hit = c_mo[3] ? a > int'(c_tb[5:0]) : a < int'(c_tb[5:0]);
        if (hit)
            v = c_mo[3] ? v + ((s * g) >>> 4) : v - ((s * g) >>> 3);
        if (hit)
            v = v < 16 ? 16 : (v > 235 ? 235 : v);
        if (c_en && (i < 3 || i > LP - 4))
            v = (v * ((i == 0 || i == LP - 1) ? 1 : (i == 1 || i == LP - 2) ? 4 : 7)) >> 3;
        return v[7:0];
    endfunction

    // ==========================================================
    // bus and stream tasks
    task chk(input string nm, input logic [31:0] ex, got);
        cmp_count++;
        if (got !== ex)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // address phase held until hready, then data phase held until hready
    task ahb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        @(posedge hclk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, wr, 2'b10, idx, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task setreg(input logic [9:0] idx, input logic [7:0] d, rb);
        ahb(1'b1, idx, d);
        ahb(1'b0, idx, 8'h00);
        chk("register readback", {24'h0, rb}, q);
    endtask

    task cfg(input logic [7:0] g, tb, mo, input logic en);
        setreg(sdlnr_pkg::IDX_GAINS, g, g);
        setreg(sdlnr_pkg::IDX_THR_BLOCK, tb, tb);
        setreg(sdlnr_pkg::IDX_MODE_OFFSET, mo, mo);
        setreg(sdlnr_pkg::IDX_EDGE_CTRL, {en, 7'h00}, {en, 7'h00});
        {c_g, c_tb, c_mo, c_en} = {g, tb, mo, en};
    endtask

    // extremes alternate in pat lines so every saturation limit is reached
    task send_line(input logic first, slow, pat);
        for (int k = 0; k < LP; k++)
        begin
            lf = lfsr(lf);
            y_line[k] = pat ? (k[0] ? 8'hff : 8'h00) : lf[7:0];
        end
        @(posedge hclk);
        {go, sof, gap} <= {1'b1, first, slow};
        @(posedge hclk);
        go <= 1'b0;
        do @(posedge hclk); while (busy === 1'b1);
        repeat (3) @(posedge hclk);
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // monitor: expectation taken at the input edge, compared at the following falling edge
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc > 60000)
        begin
            err_total++;
            results();
        end
        e = in_data;
        if (in_valid && in_luma && in_active)
        begin
            if (in_sol)
            begin
                {pidx, h1, h2} = {32'd0, in_data, in_data};
                lidx = in_sof ? 0 : lidx + 1;
            end
            e = exp_luma(in_data, h1, h2, pidx, lidx);
            {h2, h1} = {h1, in_data};
            pidx++;
        end
        {e_v, e_l, e_a, e_d} <= {in_valid, in_luma, in_active, e};
    end

    // halfway through the cycle the registered outputs are settled
    always @(negedge hclk)
    begin
        if (hresetn)
            chk("out_valid", {31'h0, e_v}, {31'h0, out_valid});
        if (hresetn && e_v)
            chk("out sample", {22'h0, e_l, e_a, e_d}, {22'h0, out_luma, out_active, out_data});
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (i_sdlnr_top.hrdata[k])
            if (k < 4)
            begin
                ahb(1'b0, k == 0 ? sdlnr_pkg::IDX_EDGE_CTRL : 10'(10'h0a2 + k), 8'h00);
                chk("reset value", 32'h0, q);
            end
        setreg(10'h001, 8'h5a, 8'h00);
        cfg(8'hff, 8'hff, 8'hf7, 1'b1);
        send_line(1'b1, 1'b0, 1'b1);
        send_line(1'b0, 1'b1, 1'b1);
        cfg(8'h9f, 8'h40, 8'h0b, 1'b1);
        send_line(1'b1, 1'b0, 1'b1);
        for (int k = 0; k < 16; k++)
        begin
            lf = lfsr(lf);
            r = lf;
            cfg(r[7:0], r[15:8], {r[23:20], k[3], k[2:0]}, r[24]);
            send_line(1'b1, r[25], 1'b0);
            send_line(1'b0, r[26], 1'b0);
        end
        results();
    end
endmodule
`default_nettype wire
